/* File: hdl/swire_host.v */
`timescale 1ns/1ns
`include "swire_host_regs.vh"

module swire_host #(
   parameter integer CLK_NS        = `CLK_PERIOD_NS,
   parameter integer WRITE_CYCLES  = (`WRITE_CYCLE_NS) / (`CLK_PERIOD_NS),
   parameter integer HS_IDLE_CYC   = (`HS_IDLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter integer SS_IDLE_CYC   = (`SS_IDLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire        clock,
   input  wire        nrst,
   // Command port
   input  wire        cmd_valid,
   output wire        cmd_ready,
   input  wire [1:0]  cmd_code,
   input  wire [7:0]  cmd_data,
   input  wire        cmd_last,
   input  wire        std_speed,
   // Answer port
   output reg         rsp_valid,
   output reg  [7:0]  rsp_data,
   output reg         rsp_nack,
   output reg         busy,
   // Open-drain line
   input  wire        line_in,
   output wire        line_out,
   output reg         line_oe
);
   // ==========================================
   // Cycle counts per speed mode
   localparam integer HS_ZERO = (`HS_ZERO_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam integer HS_ONE  = (`HS_ONE_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam integer HS_RD   = (`HS_READ_REQ_NS + CLK_NS - 1) / CLK_NS;
   localparam integer HS_SMP  = `HS_SAMPLE_NS / CLK_NS;
   localparam integer HS_BIT  = (`HS_FRAME_NS + CLK_NS - 1) / CLK_NS;
   localparam integer SS_ZERO = (`SS_ZERO_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam integer SS_ONE  = (`SS_ONE_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam integer SS_RD   = (`SS_READ_REQ_NS + CLK_NS - 1) / CLK_NS;
   localparam integer SS_SMP  = `SS_SAMPLE_NS / CLK_NS;
   localparam integer SS_BIT  = (`SS_FRAME_NS + CLK_NS - 1) / CLK_NS;

   // ==========================================
   // States
   localparam [3:0] ST_IDLE  = 4'h_1;
   localparam [3:0] ST_LOW   = 4'h_2;
   localparam [3:0] ST_HIGH  = 4'h_4;
   localparam [3:0] ST_WAIT  = 4'h_8;

   reg  [3:0]  state;
   reg  [31:0] count;
   reg  [31:0] low_len;
   reg  [31:0] frame_len;
   reg  [3:0]  bit_idx;
   reg  [7:0]  shift;
   reg  [7:0]  rx;
   reg         reading;
   reg         last;
   reg         sampled;

   // Speed-selected timing lookup
   function [31:0] timing;
      input       ss;
      input [2:0] which;
      begin
         case (which)
            3'h_0:   timing = ss ? SS_ZERO : HS_ZERO;
            3'h_1:   timing = ss ? SS_ONE : HS_ONE;
            3'h_2:   timing = ss ? SS_RD : HS_RD;
            3'h_3:   timing = ss ? SS_SMP : HS_SMP;
            3'h_4:   timing = ss ? SS_BIT : HS_BIT;
            default: timing = ss ? SS_IDLE_CYC : HS_IDLE_CYC;
         endcase
      end
   endfunction

   assign cmd_ready = (state == ST_IDLE);
   assign line_out  = 1'b0;

   // ==========================================
   // Frame engine
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state     <= ST_IDLE;
         count     <= 32'h_0000_0000;
         low_len   <= 32'h_0000_0000;
         frame_len <= 32'h_0000_0000;
         bit_idx   <= 4'h_0;
         shift     <= 8'h_00;
         rx        <= 8'h_00;
         reading   <= 1'b0;
         last      <= 1'b0;
         sampled   <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data  <= 8'h_00;
         rsp_nack  <= 1'b0;
         busy      <= 1'b0;
         line_oe   <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         case (state)
            ST_IDLE: begin
               busy <= 1'b0;
               if (cmd_valid) begin
                  busy  <= 1'b1;
                  count <= 32'h_0000_0000;
                  last  <= cmd_last;
                  if (cmd_code == `CMD_IDLE) begin
                     low_len <= timing(std_speed, 3'h_5);
                     state   <= ST_WAIT;
                  end else if (cmd_code == `CMD_WAIT_WRITE) begin
                     low_len <= WRITE_CYCLES;
                     state   <= ST_WAIT;
                  end else begin
                     reading   <= (cmd_code == `CMD_READ_BIT);
                     shift     <= cmd_data;
                     bit_idx   <= 4'h_0;
                     rx        <= 8'h_00;
                     frame_len <= timing(std_speed, 3'h_4);
                     low_len   <= (cmd_code == `CMD_READ_BIT) ? timing(std_speed, 3'h_2)
                                  : (cmd_data[7] ? timing(std_speed, 3'h_1)
                                                 : timing(std_speed, 3'h_0));
                     line_oe   <= 1'b1;
                     sampled   <= 1'b0;
                     state     <= ST_LOW;
                  end
               end
            end
            ST_LOW: begin
               count <= count + 32'h_0000_0001;
               if (count + 32'h_0000_0001 >= low_len) begin
                  line_oe <= 1'b0;
                  state   <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               count <= count + 32'h_0000_0001;
               if (reading && !sampled && count + 32'h_0000_0001 >= timing(std_speed, 3'h_3))
               begin
                  sampled <= 1'b1;
                  rx      <= {rx[6:0], line_in};
               end
               if (count + 32'h_0000_0001 >= frame_len) begin
                  count <= 32'h_0000_0000;
                  if (bit_idx == 4'h_8) begin
                     rsp_valid <= 1'b1;
                     rsp_data  <= rx;
                     rsp_nack  <= 1'b0;
                     state     <= ST_IDLE;
                  end else begin
                     bit_idx <= bit_idx + 4'h_1;
                     shift   <= {shift[6:0], 1'b0};
                     sampled <= 1'b0;
                     line_oe <= 1'b1;
                     state   <= ST_LOW;
                     if (bit_idx == 4'h_7) begin
                        // Ninth frame: acknowledge direction swaps
                        low_len <= reading ? (last ? timing(std_speed, 3'h_1)
                                                   : timing(std_speed, 3'h_0))
                                           : timing(std_speed, 3'h_2);
                        reading <= !reading;
                     end else begin
                        low_len <= reading ? timing(std_speed, 3'h_2)
                                 : (shift[6] ? timing(std_speed, 3'h_1)
                                             : timing(std_speed, 3'h_0));
                     end
                  end
               end
               if (bit_idx == 4'h_8 && count + 32'h_0000_0001 >= frame_len) begin
                  // Byte ended; deliver data and acknowledge result
                  // Read byte: rx holds the data; write byte: rx[0] is the device answer
                  rsp_data <= rx;
                  rsp_nack <= reading ? rx[0] : last;
               end
            end
            ST_WAIT: begin
               count <= count + 32'h_0000_0001;
               if (count + 32'h_0000_0001 >= low_len) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

endmodule

/* File: hdl/swire_host_regs.vh */
`ifndef SWIRE_HOST_REGS_VH
`define SWIRE_HOST_REGS_VH
// ==========================================
// Clock and timing figures (ns)
`define CLK_PERIOD_NS       8
`define HS_ZERO_PULSE_NS    8000
`define HS_ONE_PULSE_NS     1000
`define HS_READ_REQ_NS      1000
`define HS_SAMPLE_NS        2000
`define HS_FRAME_NS         15000
`define HS_IDLE_NS          150000
`define SS_ZERO_PULSE_NS    32000
`define SS_ONE_PULSE_NS     4000
`define SS_READ_REQ_NS      4000
`define SS_SAMPLE_NS        8000
`define SS_FRAME_NS         65000
`define SS_IDLE_NS          600000
`define WRITE_CYCLE_NS      5000000
// ==========================================
// Device address byte layout
`define OPC_HI              7
`define OPC_LO              4
`define SADDR_HI            3
`define SADDR_LO            1
`define RW_BIT              0
`define MADDR_IGNORED_BIT   7
// ==========================================
// Opcodes
`define OPC_MAIN            4'h_a
`define OPC_SECURITY        4'h_b
`define OPC_SEC_LOCK        4'h_2
`define OPC_ZONE            4'h_7
`define OPC_ZONE_FREEZE     4'h_1
`define OPC_ID_READ         4'h_c
`define OPC_STD_SPEED       4'h_d
`define OPC_HIGH_SPEED      4'h_e
// ==========================================
// Command codes on the user port
`define CMD_WRITE_BIT       2'h_0
`define CMD_READ_BIT        2'h_1
`define CMD_IDLE            2'h_2
`define CMD_WAIT_WRITE      2'h_3
`endif

/* File: bench/swire_host_assertions.sv */
`timescale 1ns/1ns
`include "swire_host_regs.vh"
// ==========
// Port checker
module swire_host_chk (
   // Clock, reset, command and answer
   input wire       clock,
   input wire       nrst,
   input wire       cmd_valid,
   input wire       cmd_ready,
   input wire [1:0] cmd_code,
   input wire [7:0] cmd_data,
   input wire       cmd_last,
   input wire       std_speed,
   input wire       rsp_valid,
   input wire [7:0] rsp_data,
   input wire       rsp_nack,
   input wire       busy,
   // Line
   input wire       line_in,
   input wire       line_out,
   input wire       line_oe
);
   localparam int ONE_C = 125;
   localparam int ZERO_C = 1000;
   localparam int FRAME_C = 1875;
   reg [11:0] oe_len;
   reg [11:0] gap;
   reg        oe_q;
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         oe_len <= 12'h000;
         gap <= 12'hfff;
         oe_q <= 1'b0;
      end else begin
         oe_q <= line_oe;
         oe_len <= line_oe ? oe_len + 12'h001 : 12'h000;
         gap <= (line_oe && !oe_q) ? 12'h001 : ((gap == 12'hfff) ? gap : gap + 12'h001);
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   out_low_a: assert property (line_out == 1'b0)
      else $error("line_out not low");
   pulse_len_a: assert property ($fell(line_oe) && !std_speed |->
      oe_len == ONE_C || oe_len == ZERO_C) else $error("low pulse length wrong");
   frame_len_a: assert property ($rose(line_oe) && !std_speed |-> gap >= FRAME_C)
      else $error("frame too short");
   rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
      else $error("rsp_valid longer than one cycle");
   idle_high_a: assert property (cmd_valid && cmd_ready && cmd_code == `CMD_IDLE |=>
      !line_oe [*8]) else $error("line pulled during idle");
   take_a: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
      else $error("ready after take");
   ready_oe_a: assert property (cmd_ready |-> !line_oe)
      else $error("line pulled while ready");
   rose_busy_a: assert property ($rose(line_oe) |-> !cmd_ready)
      else $error("frame outside command");
endmodule

/* File: bench/swire_dev_model.sv */
`timescale 1ns/1ns
// ==========
// Line-side memory model
module swire_dev_model #(
   parameter [2:0] SADDR = 3'h5,
   parameter [7:0] DATA  = 8'hc3
) (
   input  wire clock,
   input  wire nrst,
   input  wire line,
   output reg  pull
);
   reg  [11:0] t;
   reg  [3:0]  bitn;
   reg  [1:0]  ph;
   reg  [7:0]  sh;
   reg  [7:0]  rx;
   reg         ack_in;
   reg         last;
   wire [15:0] okset = 16'h7c86;
   wire        match = okset[rx[7:4]] && rx[3:1] == SADDR;
   wire        drv = (ph == 2'h0 && bitn == 4'h8 && match) ||
                     (ph == 2'h1 && bitn < 4'h8 && !DATA[4'h7 - bitn]);
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         t <= 12'hfff;
         bitn <= 4'h0;
         ph <= 2'h0;
         pull <= 1'b0;
         last <= 1'b1;
      end else begin
         last <= line;
         if (last && !line && !pull) t <= 12'h000;
         else if (t != 12'hfff) t <= t + 12'h001;
         if (line && t > 12'h7d0) begin
            bitn <= 4'h0;
            ph <= 2'h0;
         end
         if (t == 12'h001 && drv) pull <= 1'b1;
         if (t == 12'h177) pull <= 1'b0;
         if (t == 12'h1f4) begin
            sh <= {sh[6:0], line};
            bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
            if (bitn == 4'h7 && ph == 2'h0) rx <= {sh[6:0], line};
            if (bitn == 4'h8 && ph == 2'h1) ack_in <= line;
            if (bitn == 4'h8) ph <= (ph == 2'h0 && match && rx[0]) ? 2'h1 : 2'h2;
         end
      end
   end
endmodule

/* File: bench/swire_host_tb_top.sv */
`timescale 1ns/1ns
`include "swire_host_regs.vh"
// ==========
// Testbench
module swire_host_tb_top;
   localparam [2:0] SA = 3'h5;
   localparam [7:0] DV = 8'hc3;
   reg        clock = 1'b0;
   reg        nrst = 1'b0;
   reg        cmd_valid = 1'b0;
   reg  [1:0] cmd_code = 2'h0;
   reg  [7:0] cmd_data = 8'h00;
   reg        cmd_last = 1'b0;
   reg        std_speed = 1'b0;
   wire       cmd_ready, rsp_valid, rsp_nack, busy, line_out, line_oe, pull;
   wire [7:0] rsp_data;
   wire       line = ~((line_oe & ~line_out) | pull);
   integer    bad_count = 0;
   integer    total_checks = 0;
   always #4 clock = ~clock;
   swire_host #(.WRITE_CYCLES(50), .HS_IDLE_CYC(2200), .SS_IDLE_CYC(4400)) u_dut (
      .clock(clock), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_last(cmd_last), .std_speed(std_speed),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack), .busy(busy),
      .line_in(line), .line_out(line_out), .line_oe(line_oe));
   swire_dev_model #(.SADDR(SA), .DATA(DV)) u_dev (
      .clock(clock), .nrst(nrst), .line(line), .pull(pull));
   task results;
      begin
         if (bad_count == 0 && total_checks > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task chk(input [63:0] nm, input [7:0] exp, input [7:0] got);
      begin
         total_checks = total_checks + 1;
         if (exp !== got) begin
            $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
            bad_count = bad_count + 1;
         end
      end
   endtask
   task run(input [1:0] c, input [7:0] d, input l);
      integer i;
      reg     got;
      begin
         @(posedge clock);
         cmd_code <= c;
         cmd_data <= d;
         cmd_last <= l;
         cmd_valid <= 1'b1;
         @(posedge clock);
         cmd_valid <= 1'b0;
         @(negedge clock);
         got = (c >= `CMD_IDLE);
         for (i = 0; i < 20000 && !(got && cmd_ready === 1'b1); i = i + 1) begin
            @(negedge clock);
            if (rsp_valid === 1'b1) got = 1'b1;
         end
         if (i == 20000) begin
            bad_count = bad_count + 1;
            results;
         end
      end
   endtask
   task t_refused;
      integer   k;
      reg [7:0] a;
      begin
         for (k = 0; k < 2; k = k + 1) begin
            a = k ? {`OPC_MAIN, ~SA, 1'b0} : {4'h5, SA, 1'b0};
            run(`CMD_IDLE, 8'h00, 1'b0);
            run(`CMD_WRITE_BIT, a, 1'b0);
            chk("nack", 8'h01, {7'h00, rsp_nack});
            chk("rx", a, u_dev.rx);
         end
      end
   endtask
   task t_read;
      begin
         run(`CMD_IDLE, 8'h00, 1'b0);
         run(`CMD_WRITE_BIT, {`OPC_MAIN, SA, 1'b1}, 1'b0);
         chk("ack", 8'h00, {7'h00, rsp_nack});
         run(`CMD_READ_BIT, 8'h00, 1'b1);
         chk("rdata", DV, rsp_data);
         chk("hnack", 8'h01, {7'h00, u_dev.ack_in});
         chk("rnack", 8'h01, {7'h00, rsp_nack});
         run(`CMD_IDLE, 8'h00, 1'b0);
         run(`CMD_WAIT_WRITE, 8'h00, 1'b0);
         @(negedge clock);
         chk("busy", 8'h00, {7'h00, busy});
      end
   endtask
   initial begin
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      t_refused;
      t_read;
      results;
   end
endmodule
bind swire_host swire_host_chk u_chk (.clock(clock), .nrst(nrst), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_last(cmd_last),
   .std_speed(std_speed), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack),
   .busy(busy), .line_in(line_in), .line_out(line_out), .line_oe(line_oe));
